/* rtl/point_skid_buffer.sv */
`timescale 1ns/100ps
`default_nettype none
module point_skid_buffer #(
  parameter int WIDTH = 65,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             in_ready_r;
  wire              push;
  wire              pop;
  wire [CW-1:0]     count_nxt;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign push      = in_valid & in_ready_r;
  assign pop       = out_ready & out_valid;
  assign count_nxt = CW'(count_r + CW'(push) - CW'(pop));
  assign in_ready  = in_ready_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];

  // Storage needs no reset; only counted entries are ever read
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      in_ready_r <= 1'b0;
    end
    else
    begin
      wr_ptr_r   <= push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
      rd_ptr_r   <= pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
      count_r    <= count_nxt;
      in_ready_r <= (count_nxt != CW'(DEPTH));
    end
  end

endmodule
`default_nettype wire

/* rtl/radar_fft_frame_formatter.sv */
// Notes on behaviour
// - Both lanes use one frame layout; only lane code fields differ.
// - Range header: AA, ones at 21:20, chirp 19:11, zeros 10:9, count 8:0.
// - Range header bits 23:22 give lane: 00 lane 0, 01 lane 1.
// - Chirp number counts chirps in a radar frame, restarting at zero.
// - Range header count field is the number of points plus one.
// - Range data word: real in 31:16, imaginary in 15:0, index order.
// - Range checksum is the low 16 bits of the sum of frame data.
// - Range tail follows last data word, checksum in bits 31:16.
// - Range tail: lane at 15:14, ones at 13:12, 55 in bits 7:0.
// - Range tail bits 11:8 repeat the low four chirp number bits.
// - Doppler header: AA, lane code 10 or 11, ones down to bit 16.
// - Doppler header low half is a frame counter from zero, wrapping.
// - Doppler frame carries exactly 1024 complex data words.
// - Doppler checksum is the low 16 bits of the sum of frame data.
// - Doppler tail: checksum in 31:16, 5555 in bits 15:0.
// - Range or Doppler frames are selectable; only the chosen type is sent.
`timescale 1ns/100ps
`default_nettype none
module radar_fft_frame_formatter
  import radar_frame_pkg::*;
#(
  // Point buffer depth and Doppler words per frame; a smaller DPL_WORDS only serves to shorten simulations
  parameter int          DEPTH     = radar_frame_pkg::BUF_DEPTH,
  parameter logic [10:0] DPL_WORDS = radar_frame_pkg::DOPPLER_WORDS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Configuration
  input  wire logic        doppler_mode,
  input  wire logic [8:0]  points_count,
  // Point stream
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic        in_first_chirp,
  input  wire logic [31:0] lane0_point,
  input  wire logic [31:0] lane1_point,
  // Serial link
  input  wire logic        link_clk,
  output logic             lane0_data,
  output logic             lane1_data,
  output logic             word_valid
);

  import radar_frame_pkg::*;

  // ----------------------------------------------------------------
  // Word builders
  // ----------------------------------------------------------------
  function automatic logic [31:0] head_word(input logic dpl, input logic lane,
                                            input logic [8:0] chirp,
                                            input logic [8:0] cnt1,
                                            input logic [15:0] fcnt);
    if (dpl)
      head_word = {SYNC_BYTE, 1'b1, lane, ONES2, ONES4, fcnt};
    else
      head_word = {SYNC_BYTE, 1'b0, lane, ONES2, chirp, ZEROS2, cnt1};
  endfunction

  function automatic logic [31:0] tail_word(input logic dpl, input logic lane,
                                            input logic [15:0] sum,
                                            input logic [3:0] chirp_lo);
    if (dpl)
      tail_word = {sum, DOPPLER_TAIL};
    else
      tail_word = {sum, 1'b0, lane, ONES2, chirp_lo, TAIL_BYTE};
  endfunction

  // Adding the full word and keeping 16 bits equals adding its low half
  function automatic logic [15:0] csum_add(input logic [15:0] sum,
                                           input logic [31:0] word);
    logic [31:0] full;
    full     = {16'h0000, sum} + word;
    csum_add = full[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Point buffer
  // ----------------------------------------------------------------
  wire        buf_valid;
  wire        buf_ready;
  wire [64:0] buf_data;
  wire [31:0] buf_lane0;
  wire [31:0] buf_lane1;
  wire        buf_first;

  point_skid_buffer #(
    .WIDTH (65),
    .DEPTH (DEPTH)
  ) u_buffer (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_first_chirp, lane1_point, lane0_point}),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  assign buf_lane0 = buf_data[31:0];
  assign buf_lane1 = buf_data[63:32];
  assign buf_first = buf_data[64];

  // ----------------------------------------------------------------
  // Link clock sampling
  // ----------------------------------------------------------------
  // The link clock is slow enough to be sampled; bits change after its fall
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;
  wire  link_fall;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
    end
    else
    begin
      sclk_s1_r <= link_clk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
    end
  end

  assign link_fall = sclk_s3_r & ~sclk_s2_r;

  // ----------------------------------------------------------------
  // Sequencer decode
  // ----------------------------------------------------------------
  frame_state_t state_r;
  frame_state_t state_nxt;
  logic [31:0]  sh0_r;
  logic [31:0]  sh1_r;
  logic [4:0]   bit_cnt_r;
  logic         valid_r;
  logic         mode_r;
  logic [10:0]  total_r;
  logic [10:0]  word_idx_r;
  logic [15:0]  sum0_r;
  logic [15:0]  sum1_r;
  logic [8:0]   chirp_r;
  logic [15:0]  dpl_r;

  wire          shifting;
  wire          word_end;
  wire          mid_frame;
  wire          data_left;
  wire          hdr_load;
  wire          data_load;
  wire          tail_load;
  wire          stall;
  wire          frame_done;
  wire          shift;
  wire [8:0]    chirp_nxt;
  wire [8:0]    cnt_plus_one;
  wire [10:0]   total_nxt;

  assign shifting   = (state_r == st_head) || (state_r == st_data) || (state_r == st_tail);
  assign word_end   = link_fall && (!shifting || bit_cnt_r == LAST_BIT);
  assign mid_frame  = word_end && ((state_r == st_head) || (state_r == st_data)
                                   || (state_r == st_wait));
  assign data_left  = (word_idx_r != total_r);
  assign hdr_load   = word_end && (state_r == st_idle) && buf_valid;
  assign data_load  = mid_frame && data_left && buf_valid;
  assign tail_load  = mid_frame && !data_left;
  // A late point holds the link idle rather than sending a stale word
  assign stall      = mid_frame && data_left && !buf_valid;
  assign frame_done = word_end && (state_r == st_tail);
  assign shift      = link_fall && shifting && !word_end;
  assign buf_ready  = data_load;

  assign chirp_nxt    = buf_first ? 9'h000 : 9'(chirp_r + 9'h001);
  assign cnt_plus_one = 9'(points_count + 9'h001);
  // Mode is taken at the header so a frame never changes type midway
  assign total_nxt    = doppler_mode ? DPL_WORDS
                                     : {2'b00, points_count};

  always_comb
  begin
    state_nxt = state_r;
    if (hdr_load)
      state_nxt = st_head;
    else if (tail_load)
      state_nxt = st_tail;
    else if (data_load)
      state_nxt = st_data;
    else if (stall)
      state_nxt = st_wait;
    else if (frame_done)
      state_nxt = st_idle;
  end

  // ----------------------------------------------------------------
  // Shift registers
  // ----------------------------------------------------------------
  wire [31:0] sh0_nxt;
  wire [31:0] sh1_nxt;

  assign sh0_nxt = hdr_load  ? head_word(doppler_mode, 1'b0, chirp_nxt, cnt_plus_one, dpl_r)
                 : data_load ? buf_lane0
                 : tail_load ? tail_word(mode_r, 1'b0, sum0_r, chirp_r[3:0])
                 : shift     ? {sh0_r[30:0], 1'b0}
                 : sh0_r;
  assign sh1_nxt = hdr_load  ? head_word(doppler_mode, 1'b1, chirp_nxt, cnt_plus_one, dpl_r)
                 : data_load ? buf_lane1
                 : tail_load ? tail_word(mode_r, 1'b1, sum1_r, chirp_r[3:0])
                 : shift     ? {sh1_r[30:0], 1'b0}
                 : sh1_r;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r   <= st_idle;
      sh0_r     <= '0;
      sh1_r     <= '0;
      bit_cnt_r <= '0;
      valid_r   <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      sh0_r     <= sh0_nxt;
      sh1_r     <= sh1_nxt;
      bit_cnt_r <= (hdr_load || data_load || tail_load) ? 5'h00
                 : shift ? 5'(bit_cnt_r + 5'h01) : bit_cnt_r;
      valid_r   <= (hdr_load || data_load || tail_load) ? 1'b1
                 : (stall || frame_done) ? 1'b0 : valid_r;
    end
  end

  // ----------------------------------------------------------------
  // Frame bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r     <= 1'b0;
      total_r    <= '0;
      word_idx_r <= '0;
    end
    else if (hdr_load)
    begin
      mode_r     <= doppler_mode;
      total_r    <= total_nxt;
      word_idx_r <= '0;
    end
    else if (data_load)
    begin
      word_idx_r <= 11'(word_idx_r + 11'h001);
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sum0_r <= '0;
      sum1_r <= '0;
    end
    else if (hdr_load)
    begin
      sum0_r <= '0;
      sum1_r <= '0;
    end
    else if (data_load)
    begin
      sum0_r <= csum_add(sum0_r, buf_lane0);
      sum1_r <= csum_add(sum1_r, buf_lane1);
    end
  end

  // Chirp number starts one below zero so an unflagged first chirp reads 0
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      chirp_r <= CHIRP_RESET;
      dpl_r   <= DPL_RESET;
    end
    else
    begin
      chirp_r <= (hdr_load && !doppler_mode) ? chirp_nxt : chirp_r;
      dpl_r   <= (frame_done && mode_r) ? 16'(dpl_r + 16'h0001) : dpl_r;
    end
  end

  assign lane0_data = sh0_r[31];
  assign lane1_data = sh1_r[31];
  assign word_valid = valid_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  sequence hdr_load_s;
    hdr_load;
  endsequence

  sequence dpl_end_s;
    frame_done && mode_r;
  endsequence

  sequence range_tail_s;
    tail_load && !mode_r;
  endsequence

  chk_head_sync_lane: assert property (hdr_load_s |=> sh0_r[31:24] == SYNC_BYTE
      && sh1_r[31:24] == SYNC_BYTE && sh0_r[23:22] == {mode_r, 1'b0}
      && sh1_r[23:22] == {mode_r, 1'b1} && sh0_r[21:20] == ONES2)
    else $error("header sync or lane code wrong");

  chk_lanes_alike: assert property (hdr_load_s |=> sh0_r[21:0] == sh1_r[21:0])
    else $error("lane headers differ outside lane code");

  chk_count_field: assert property (hdr_load && !doppler_mode
      |=> sh0_r[8:0] == 9'(total_r[8:0] + 9'h001) && sh0_r[10:9] == ZEROS2)
    else $error("range count field wrong");

  chk_chirp_restart: assert property (hdr_load && !doppler_mode && buf_first
      |=> sh0_r[19:11] == 9'h000 && chirp_r == 9'h000)
    else $error("chirp number did not restart");

  chk_data_word: assert property (data_load
      |=> sh0_r == $past(buf_lane0) && sh1_r == $past(buf_lane1) && valid_r)
    else $error("data word not loaded as taken");

  chk_range_tail: assert property (range_tail_s |=> sh0_r[13:12] == ONES2
      && sh0_r[7:0] == TAIL_BYTE && sh0_r[11:8] == chirp_r[3:0]
      && sh0_r[15:14] == 2'h0 && sh1_r[15:14] == 2'h1)
    else $error("range tail fixed fields wrong");

  chk_tail_checksum: assert property (tail_load
      |=> sh0_r[31:16] == $past(sum0_r) && sh1_r[31:16] == $past(sum1_r))
    else $error("tail checksum wrong");

  chk_doppler_tail: assert property (tail_load && mode_r
      |-> word_idx_r == DPL_WORDS ##1 sh0_r[15:0] == DOPPLER_TAIL)
    else $error("doppler tail or length wrong");

  chk_doppler_count: assert property (dpl_end_s
      |=> dpl_r == 16'($past(dpl_r) + 16'h0001))
    else $error("doppler frame counter did not step");

  chk_mode_hold: assert property (state_r != st_idle && !hdr_load
      |=> $stable(mode_r))
    else $error("frame type changed inside a frame");

endmodule
`default_nettype wire

/* rtl/radar_frame_pkg.sv */
package radar_frame_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          WORD_W        = 32;
  localparam logic [7:0]  SYNC_BYTE     = 8'hAA;
  localparam logic [7:0]  TAIL_BYTE     = 8'h55;
  localparam logic [15:0] DOPPLER_TAIL  = 16'h5555;
  localparam logic [1:0]  ONES2         = 2'h3;
  localparam logic [1:0]  ZEROS2        = 2'h0;
  localparam logic [3:0]  ONES4         = 4'hF;
  localparam logic [10:0] DOPPLER_WORDS = 11'h400;

  // ----------------------------------------------------------------
  // Values after reset and counts
  // ----------------------------------------------------------------
  localparam logic [8:0]  CHIRP_RESET   = 9'h1FF;
  localparam logic [15:0] DPL_RESET     = 16'h0000;
  localparam logic [4:0]  LAST_BIT      = 5'h1F;
  localparam int          BUF_DEPTH     = 2;

  // ----------------------------------------------------------------
  // Word sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_head,
    st_data,
    st_wait,
    st_tail
  } frame_state_t;

endpackage

/* test/host_link_receiver.sv */
`timescale 1ns/100ps
`default_nettype none
module host_link_receiver #(
  parameter int HALF_NS = 400
) (
  // Bench control
  input  wire logic   run,
  // Serial link
  input  wire logic   lane0_data,
  input  wire logic   lane1_data,
  input  wire logic   word_valid,
  output logic        link_clk,
  // Assembled words
  output logic        word_done,
  output logic [31:0] rx_word0,
  output logic [31:0] rx_word1
);
  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic [31:0] shift0;
  logic [31:0] shift1;
  int          nbits;

  initial
  begin
    link_clk  = 1'b1;
    word_done = 1'b0;
    rx_word0  = 32'h0000_0000;
    rx_word1  = 32'h0000_0000;
    shift0    = 32'h0000_0000;
    shift1    = 32'h0000_0000;
    nbits     = 0;
    forever
    begin
      // Clock stands high between frames, so the first edge seen is a fall
      wait (run === 1'b1);
      #13;
      while (run === 1'b1)
      begin
        #HALF_NS;
        link_clk  = 1'b0;
        word_done = 1'b0;
        #HALF_NS;
        link_clk = 1'b1;
        // Bits without word_valid are gap filler and are dropped
        if (word_valid === 1'b1)
        begin
          shift0 = {shift0[30:0], lane0_data};
          shift1 = {shift1[30:0], lane1_data};
          nbits++;
          if (nbits == 32)
          begin
            rx_word0  = shift0;
            rx_word1  = shift1;
            word_done = 1'b1;
            nbits     = 0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock;
  logic        resetn;
  logic        doppler_mode;
  logic [8:0]  points_count;
  logic        in_valid;
  logic        in_ready;
  logic        in_first_chirp;
  logic [31:0] lane0_point;
  logic [31:0] lane1_point;
  logic        link_clk;
  logic        lane0_data;
  logic        lane1_data;
  logic        word_valid;
  logic        run;
  logic        word_done;
  logic [31:0] rx_word0;
  logic [31:0] rx_word1;
  logic [31:0] rx0[$];
  logic [31:0] rx1[$];
  int          bad_count;
  int          n_tests;
  // Doppler frame shortened so the run stays within its cycle budget
  localparam logic [10:0] DPL_N = 11'h010;

  radar_fft_frame_formatter #(.DEPTH(2), .DPL_WORDS(DPL_N)) i_dut (
    .clock(clock), .resetn(resetn), .doppler_mode(doppler_mode),
    .points_count(points_count), .in_valid(in_valid), .in_ready(in_ready),
    .in_first_chirp(in_first_chirp), .lane0_point(lane0_point),
    .lane1_point(lane1_point), .link_clk(link_clk), .lane0_data(lane0_data),
    .lane1_data(lane1_data), .word_valid(word_valid)
  );

  host_link_receiver #(.HALF_NS(400)) i_host (
    .run(run), .lane0_data(lane0_data), .lane1_data(lane1_data),
    .word_valid(word_valid), .link_clk(link_clk), .word_done(word_done),
    .rx_word0(rx_word0), .rx_word1(rx_word1)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge word_done)
  begin
    rx0.push_back(rx_word0);
    rx1.push_back(rx_word1);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pt(input int i, input logic l);
    if (l)
      return {16'(i * 7 + 32'h8000), 16'(32'hF00D - i)};
    return {16'(i * 3 + 32'h7FF0), 16'(i * 5 + 32'hC000)};
  endfunction

  function automatic logic [31:0] rxw(input int l, input int j);
    return (l == 1) ? rx1[j] : rx0[j];
  endfunction

  task automatic results;
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic stalled(input string what);
    bad_count++;
    $display("BAD %s expected done seen timeout", what);
    results();
  endtask

  // Holds each point until in_ready is seen ahead of the taking edge
  task automatic feed(input int from, input int upto, input logic first, input int gap);
    int k;
    for (int i = from; i < upto; i++)
    begin
      @(negedge clock);
      in_valid       = 1'b1;
      in_first_chirp = first && (i == 0);
      lane0_point    = pt(i, 1'b0);
      lane1_point    = pt(i, 1'b1);
      k              = 0;
      while (in_ready !== 1'b1)
      begin
        @(negedge clock);
        k++;
        if (k > 5000)
          stalled("in_ready");
      end
      if (gap > 0)
      begin
        @(negedge clock);
        in_valid = 1'b0;
        repeat (gap - 1) @(negedge clock);
      end
    end
    @(negedge clock);
    in_valid = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // One frame: feed, receive, compare both lanes
  // ----------------------------------------------------------------
  task automatic run_frame(input logic dop, input int m, input logic first, input int gap,
                           input logic hold, input logic [8:0] chirp,
                           input logic [15:0] fcnt);
    int          n;
    int          k;
    logic [31:0] sum32;
    logic [31:0] exp_w;
    n = dop ? int'(DPL_N) : m;
    rx0.delete();
    rx1.delete();
    @(negedge clock);
    doppler_mode = dop;
    points_count = 9'(m);
    // Link held still: the buffer fills and must refuse a third point
    if (hold)
    begin
      feed(0, 2, first, 0);
      @(negedge clock);
      `CHECK("in_ready full", 1'b0, in_ready)
    end
    run = 1'b1;
    feed(hold ? 2 : 0, n, first, gap);
    k = 0;
    while (rx0.size() < n + 2)
    begin
      @(negedge clock);
      k++;
      if (k > 20000)
        stalled("frame words");
    end
    repeat (600) @(negedge clock);
    run = 1'b0;
    repeat (20) @(negedge clock);
    `CHECK("word count", n + 2, rx0.size())
    for (int l = 0; l < 2; l++)
    begin
      sum32 = 32'h0000_0000;
      if (dop)
        exp_w = {8'hAA, 1'b1, l[0], 2'b11, 4'hF, fcnt};
      else
        exp_w = {8'hAA, 1'b0, l[0], 2'b11, chirp, 2'b00, 9'(m + 1)};
      `CHECK("header word", exp_w, rxw(l, 0))
      for (int i = 0; i < n; i++)
      begin
        exp_w = pt(i, l[0]);
        sum32 = sum32 + exp_w;
        `CHECK("data word", exp_w, rxw(l, i + 1))
      end
      if (dop)
        exp_w = {sum32[15:0], 16'h5555};
      else
        exp_w = {sum32[15:0], 1'b0, l[0], 2'b11, chirp[3:0], 8'h55};
      `CHECK("tail word", exp_w, rxw(l, n + 1))
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    resetn         = 1'b0;
    doppler_mode   = 1'b0;
    points_count   = 9'h000;
    in_valid       = 1'b0;
    in_first_chirp = 1'b0;
    lane0_point    = 32'h0000_0000;
    lane1_point    = 32'h0000_0000;
    run            = 1'b0;
    bad_count      = 0;
    n_tests        = 0;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    `CHECK("word_valid idle", 1'b0, word_valid)
    // Full buffer first, then slow feed forcing gaps, then two Doppler, then range again
    run_frame(1'b0, 3, 1'b1, 0, 1'b1, 9'h000, 16'h0000);
    run_frame(1'b0, 4, 1'b0, 400, 1'b0, 9'h001, 16'h0000);
    run_frame(1'b1, 0, 1'b0, 0, 1'b0, 9'h000, 16'h0000);
    run_frame(1'b1, 0, 1'b0, 0, 1'b0, 9'h000, 16'h0001);
    run_frame(1'b0, 2, 1'b0, 0, 1'b0, 9'h002, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
